//--- hw/smm_master.sv
// Behaviour
// - Mode 3: clock idles high, sample rising.
// - Phase bits cleared, selecting phase type one.
// - Master alone generates the serial clock.
// - Before enable, output and clock driven high.
// - Enable hands pins to serial function.
// - Enable loads the bit rate setting.
// - Disabled mode drives output and clock high.
// - Open mode drives no serial pin.
// - Transmit, receive and combined transfers offered.
// - Select is separate output, not serial unit.
// - Select setup time before first falling edge.
// - Select hold time after final rising edge.
// - Bytes move in order, no reordering.
// - Wait four clocks before reconfiguring pins.
module smm_master #(
    parameter int DIV_W    = 8,
    parameter int SETUP_NS = 100,
    parameter int HOLD_NS  = 100
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    input  wire logic                 cmd_valid_in,
    output logic                      cmd_ready_out,
    input  wire logic [1:0]           cmd_mode_in,
    input  wire logic [DIV_W-1:0]     baud_in,
    output logic [1:0]                mode_out,
    input  wire logic                 req_valid_in,
    output logic                      req_ready_out,
    input  wire logic [1:0]           req_kind_in,
    input  wire logic [7:0]           tx_data_in,
    output logic                      rx_valid_out,
    output logic [7:0]                rx_data_out,
    input  wire logic                 cs_select_in,
    output logic                      cs_n_out,
    output logic                      sck_out,
    output logic                      sck_oe_out,
    output logic                      sdo_out,
    output logic                      sdo_oe_out,
    input  wire logic                 sdi_in
);

    localparam int         SETUP_RAW = (SETUP_NS + smm_pkg::CLK_PERIOD_NS - 1) / smm_pkg::CLK_PERIOD_NS;
    localparam int         HOLD_RAW  = (HOLD_NS + smm_pkg::CLK_PERIOD_NS - 1) / smm_pkg::CLK_PERIOD_NS;
    localparam int         SETUP_CYC = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
    localparam int         HOLD_CYC  = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    localparam logic [15:0] SETUP_LD = 16'(SETUP_CYC);
    localparam logic [15:0] HOLD_LD  = 16'(HOLD_CYC);

    smm_pkg::smm_state_type state_q, state_d;
    smm_pkg::smm_mode_type  mode_q;
    logic [DIV_W-1:0] baud_q;
    logic [DIV_W-1:0] div_q;
    logic [2:0]       start_q;
    logic [2:0]       bit_q;
    logic [1:0]       kind_q;
    logic [7:0]       tx_q;
    logic [7:0]       rx_q;
    logic [7:0]       rx_data_q;
    logic             rx_valid_q;
    logic             sck_q;
    logic             sdo_q;
    logic             cs_n_q, cs_n_d;
    logic [15:0]      setup_q;
    logic [15:0]      hold_q;
    logic             sdi_s1_q;
    logic             sdi_s2_q;

    // Decoded events of the bit engine.
    wire started_w  = start_q == smm_pkg::STARTUP_CYCLES;
    wire idle_w     = state_q == smm_pkg::ST_IDLE;
    wire div_zero_w = div_q == '0;
    wire cmd_take_w = cmd_valid_in && cmd_ready_out;
    wire start_w    = req_valid_in && req_ready_out;
    wire rise_w     = (state_q == smm_pkg::ST_LOW) && div_zero_w;
    wire half_end_w = (state_q == smm_pkg::ST_HIGH) && div_zero_w;
    wire last_w     = bit_q == smm_pkg::LAST_BIT;
    wire fall_w     = start_w || (half_end_w && !last_w);
    wire done_w     = half_end_w && last_w;
    wire last_rise_w = rise_w && last_w;
    wire cs_fall_w  = cs_n_q && !cs_n_d;

    // Mode changes wait for the startup count and an idle engine.
    assign cmd_ready_out = started_w && idle_w;
    // A byte starts only when enabled, idle and the select setup has elapsed.
    assign req_ready_out = idle_w && (mode_q == smm_pkg::MODE_ENABLED) && (setup_q == '0);
    assign mode_out      = mode_q;
    assign rx_valid_out  = rx_valid_q;
    assign rx_data_out   = rx_data_q;
    assign cs_n_out      = cs_n_q;

    // Pin drive: open mode releases both outputs, other modes drive them.
    assign sck_out    = sck_q;
    assign sdo_out    = sdo_q;
    assign sck_oe_out = mode_q != smm_pkg::MODE_OPEN;
    assign sdo_oe_out = mode_q != smm_pkg::MODE_OPEN;

    // Select falls at once on request; it rises only after the hold count expires.
    always_comb begin
        cs_n_d = cs_n_q;
        if (cs_select_in) begin
            cs_n_d = 1'b0;
        end else if (idle_w && (hold_q == '0)) begin
            cs_n_d = 1'b1;
        end
    end

    // Engine sequencing: falling edge, low half, rising edge, high half.
    always_comb begin
        state_d = state_q;
        case (state_q)
            smm_pkg::ST_IDLE: begin
                if (start_w) begin
                    state_d = smm_pkg::ST_LOW;
                end
            end
            smm_pkg::ST_LOW: begin
                if (div_zero_w) begin
                    state_d = smm_pkg::ST_HIGH;
                end
            end
            smm_pkg::ST_HIGH: begin
                if (done_w) begin
                    state_d = smm_pkg::ST_IDLE;
                end else if (div_zero_w) begin
                    state_d = smm_pkg::ST_LOW;
                end
            end
            default: begin
                state_d = smm_pkg::ST_IDLE;
            end
        endcase
    end

    // The serial input is a pin, so it passes two flops before use.
    always_ff @(posedge clk_in) begin
        sdi_s1_q <= sdi_in;
        sdi_s2_q <= sdi_s1_q;
    end

    // Mode, rate and startup count; the rate is latched only on enable.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode_q  <= smm_pkg::MODE_DISABLED;
            baud_q  <= DIV_W'(smm_pkg::RESET_BAUD);
            start_q <= '0;
        end else begin
            if (!started_w) begin
                start_q <= start_q + 3'h1;
            end
            if (cmd_take_w && (cmd_mode_in == smm_pkg::MODE_ENABLED)) begin
                mode_q <= smm_pkg::MODE_ENABLED;
                baud_q <= baud_in;
            end else if (cmd_take_w && (cmd_mode_in == smm_pkg::MODE_OPEN)) begin
                mode_q <= smm_pkg::MODE_OPEN;
            end else if (cmd_take_w) begin
                mode_q <= smm_pkg::MODE_DISABLED;
            end
        end
    end

    // Half-period divider and bit counter; the rate register alone sets the clock.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= smm_pkg::ST_IDLE;
            div_q   <= '0;
            bit_q   <= '0;
        end else begin
            state_q <= state_d;
            if (start_w || div_zero_w) begin
                div_q <= baud_q;
            end else begin
                div_q <= div_q - 1'b1;
            end
            if (start_w) begin
                bit_q <= '0;
            end else if (fall_w) begin
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    // Clock and data pins: data changes on the falling edge and is sampled
    // on the rising edge, so both lines idle high between frames.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sck_q <= smm_pkg::SCK_IDLE;
            sdo_q <= smm_pkg::PIN_HIGH;
        end else if (fall_w) begin
            sck_q <= smm_pkg::CLOCK_PHASE_BIT;
            sdo_q <= start_w ? (req_kind_in[0] ? tx_data_in[7] : smm_pkg::PIN_HIGH) : tx_q[7];
        end else if (rise_w) begin
            sck_q <= smm_pkg::SCK_IDLE;
        end else if (done_w) begin
            sdo_q <= smm_pkg::PIN_HIGH;
        end
    end

    // Shift registers; receive-only frames send all ones.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_q   <= smm_pkg::IDLE_BYTE;
            rx_q   <= '0;
            kind_q <= smm_pkg::KIND_TRX;
        end else begin
            if (start_w) begin
                tx_q   <= req_kind_in[0] ? {tx_data_in[6:0], smm_pkg::DATA_PHASE_BIT} : smm_pkg::IDLE_BYTE;
                kind_q <= req_kind_in;
            end else if (fall_w) begin
                tx_q <= {tx_q[6:0], smm_pkg::DATA_PHASE_BIT};
            end
            if (rise_w) begin
                rx_q <= {rx_q[6:0], sdi_s2_q};
            end
        end
    end

    // Finished bytes of receive and combined frames are handed out one per frame, in link order.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= '0;
        end else begin
            rx_valid_q <= done_w && kind_q[1];
            if (done_w && kind_q[1]) begin
                rx_data_q <= rx_q;
            end
        end
    end

    // Select timing counters; setup starts at the select fall, hold at the last rise.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cs_n_q  <= 1'b1;
            setup_q <= '0;
            hold_q  <= '0;
        end else begin
            cs_n_q <= cs_n_d;
            if (cs_fall_w) begin
                setup_q <= SETUP_LD;
            end else if (setup_q != '0) begin
                setup_q <= setup_q - 16'h1;
            end
            if (last_rise_w) begin
                hold_q <= HOLD_LD;
            end else if (hold_q != '0) begin
                hold_q <= hold_q - 16'h1;
            end
        end
    end

    // Helper counters that only the checks below read.
    logic [15:0] since_fall_q;
    logic [15:0] since_rise_q;
    logic [3:0]  falls_q;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            since_fall_q <= 16'hffff;
            since_rise_q <= 16'hffff;
            falls_q      <= '0;
        end else begin
            since_fall_q <= cs_fall_w ? 16'h0 : (since_fall_q == 16'hffff ? since_fall_q : since_fall_q + 16'h1);
            since_rise_q <= last_rise_w ? 16'h0 : (since_rise_q == 16'hffff ? since_rise_q : since_rise_q + 16'h1);
            falls_q      <= start_w ? 4'h1 : (fall_w ? falls_q + 4'h1 : falls_q);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    clock_idle_a : assert property (idle_w |-> sck_q == 1'b1)
        else $error("Clock not high while idle.");
    sample_edge_a : assert property (rise_w |=> sck_q && rx_q[0] == $past(sdi_s2_q))
        else $error("Input not sampled at rise.");
    open_release_a : assert property (mode_q == smm_pkg::MODE_OPEN |-> !sck_oe_out && !sdo_oe_out)
        else $error("Open mode drives a pin.");
    disabled_high_a : assert property (mode_q == smm_pkg::MODE_DISABLED |->
        sck_oe_out && sck_out && sdo_oe_out && sdo_out) else $error("Disabled pins not high.");
    rate_load_a : assert property (cmd_take_w && cmd_mode_in == smm_pkg::MODE_ENABLED |=>
        baud_q == $past(baud_in) && mode_q == smm_pkg::MODE_ENABLED) else $error("Rate not loaded on enable.");
    startup_wait_a : assert property ($rose(started_w) |-> !$past(cmd_ready_out, 4))
        else $error("Command taken too early.");
    cs_setup_a : assert property ($fell(sck_q) && !cs_n_q |-> since_fall_q >= 16'(SETUP_CYC))
        else $error("Select setup too short.");
    cs_hold_a : assert property ($rose(cs_n_q) |-> since_rise_q > 16'(HOLD_CYC))
        else $error("Select hold too short.");
    frame_bits_a : assert property (done_w |-> falls_q == 4'(smm_pkg::FRAME_BITS))
        else $error("Frame is not eight bits.");
    rx_order_a : assert property (done_w && kind_q[1] |=> rx_valid_out && rx_data_out == $past(rx_q))
        else $error("Byte not delivered.");
    cs_follow_a : assert property (cs_select_in |=> !cs_n_out)
        else $error("Select did not fall.");

    // The first bit must leave with the first falling edge, and the rate may only move on an
    // enable command, because a frame that changed speed halfway would break the slave's timing.
    tx_msb_a : assert property (start_w && req_kind_in[0] |=> sdo_q == $past(tx_data_in[7]))
        else $error("First bit is not the top bit.");
    rx_fill_a : assert property (start_w && !req_kind_in[0] |=> sdo_q)
        else $error("Receive frame does not send ones.");
    enable_pins_a : assert property (mode_q == smm_pkg::MODE_ENABLED |-> sck_oe_out && sdo_oe_out)
        else $error("Enabled pins not driven.");
    idle_data_a : assert property (idle_w |-> sdo_q)
        else $error("Data line not high while idle.");
    rate_hold_a : assert property (!(cmd_take_w && cmd_mode_in == smm_pkg::MODE_ENABLED) |=> $stable(baud_q))
        else $error("Rate moved without enable.");

    tx_byte_c : cover property (start_w && req_kind_in == smm_pkg::KIND_TX);
    rx_byte_c : cover property (rx_valid_out && kind_q == smm_pkg::KIND_RX);
    back_to_back_c : cover property (done_w ##1 start_w);
    open_mode_c : cover property (mode_q == smm_pkg::MODE_OPEN);
    select_cycle_c : cover property ($rose(cs_n_q));

endmodule : smm_master

//--- hw/smm_pkg.sv
package smm_pkg;

    // Pin state modes; the block leaves reset in the disabled mode.
    typedef enum logic [1:0] {
        MODE_OPEN     = 2'b00,
        MODE_DISABLED = 2'b01,
        MODE_ENABLED  = 2'b10
    } smm_mode_type;

    // Transfer kinds; bit 0 means the byte is sent, bit 1 means it is returned.
    typedef enum logic [1:0] {
        KIND_TX  = 2'b01,
        KIND_RX  = 2'b10,
        KIND_TRX = 2'b11
    } smm_kind_type;

    // Bit engine states: idle, clock low half, clock high half.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10
    } smm_state_type;

    localparam int         CLK_PERIOD_NS  = 8;
    localparam int         FRAME_BITS     = 8;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam logic [2:0] STARTUP_CYCLES = 3'h4;
    localparam logic [7:0] IDLE_BYTE      = 8'hff;
    localparam logic [7:0] RESET_BAUD     = 8'h00;
    localparam logic       DATA_PHASE_BIT  = 1'b0;
    localparam logic       CLOCK_PHASE_BIT = 1'b0;
    localparam logic       SCK_IDLE        = ~CLOCK_PHASE_BIT;
    localparam logic       PIN_HIGH        = 1'b1;

endpackage : smm_pkg

//--- test/smm_slave_model.sv
// Behavioural mode 3 slave: shifts its reply out on falling clock, samples on rising clock.
module smm_slave_model (
    input  wire logic       cs_n_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic [7:0] reply_in,
    output logic            miso_out,
    output logic [7:0]      got_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    initial begin
        miso_out = 1'b0;
        got_out  = 8'h00;
        shift_q  = 8'h00;
        bit_q    = 3'h0;
    end
    // A released line must not look like a held bit, so deselect flips it.
    always @(posedge cs_n_in) miso_out = ~miso_out;
    always @(negedge cs_n_in) bit_q = 3'h0;
    // Reply bits leave on the falling edge, most significant first.
    always @(negedge sck_in) begin
        if (!cs_n_in) miso_out = reply_in[3'h7 - bit_q];
    end
    // Master data is taken on the rising edge; a full byte is published.
    always @(posedge sck_in) begin
        if (!cs_n_in) begin
            shift_q = {shift_q[6:0], mosi_in};
            if (bit_q == 3'h7) got_out = shift_q;
            bit_q = bit_q + 3'h1;
        end
    end
endmodule : smm_slave_model

//--- test/tb_spi_mode3_single_master.sv
module tb_spi_mode3_single_master;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 8; // 64 ns of select setup and hold at 8 ns a cycle.
    logic       clk_in, reset_in, cmd_valid_in, req_valid_in, cs_select_in, sdi_in;
    logic       cmd_ready_out, req_ready_out, rx_valid_out, cs_n_out;
    logic       sck_out, sck_oe_out, sdo_out, sdo_oe_out, sck_w, sdo_w, sck_p, cs_p, armed;
    logic [1:0] cmd_mode_in, req_kind_in, mode_out;
    logic [7:0] baud_in, tx_data_in, rx_data_out, reply, got;
    int         errors, comparisons, cycles, since_cs, since_rise;

    smm_master #(.DIV_W(8), .SETUP_NS(64), .HOLD_NS(64)) uut (
        .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
        .cmd_mode_in(cmd_mode_in), .baud_in(baud_in), .mode_out(mode_out), .req_valid_in(req_valid_in),
        .req_ready_out(req_ready_out), .req_kind_in(req_kind_in), .tx_data_in(tx_data_in),
        .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .cs_select_in(cs_select_in),
        .cs_n_out(cs_n_out), .sck_out(sck_out), .sck_oe_out(sck_oe_out), .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out), .sdi_in(sdi_in));
    // Board pull-ups hold the lines high when the master lets go of them.
    assign sck_w = sck_oe_out ? sck_out : 1'b1;
    assign sdo_w = sdo_oe_out ? sdo_out : 1'b1;
    smm_slave_model slave (.cs_n_in(cs_n_out), .sck_in(sck_w), .mosi_in(sdo_w), .reply_in(reply),
        .miso_out(sdi_in), .got_out(got));

    always #4 clk_in = ~clk_in;

    task automatic chk_val(input string name, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk_val

    task automatic chk_min(input string name, input int exp, input int seen);
        comparisons++;
        if (seen < exp) begin
            errors++;
            $display("[FAIL] %s expected at least %0d seen %0d", name, exp, seen);
        end
    endtask : chk_min

    // Select timing is watched on settled values, half a cycle after each edge.
    always @(negedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
        since_cs   = cs_n_out ? 0 : since_cs + 1;
        since_rise = (sck_out && !sck_p) ? 0 : since_rise + 1;
        if (!reset_in && !cs_n_out && cs_p) armed = 1'b1;
        if (armed && sck_p && !sck_out) begin
            chk_min("select setup", GAP, since_cs - 1);
            armed = 1'b0;
        end
        if (!reset_in && cs_n_out && !cs_p) chk_min("select hold", GAP, since_rise);
        if (!reset_in && mode_out == 2'b10 && cs_n_out) chk_val("sck idle", 8'h01, {7'h0, sck_out});
        sck_p = sck_out;
        cs_p  = cs_n_out;
    end

    task automatic set_mode(input logic [1:0] m, input logic [7:0] b);
        // One edge passes first, so a back-to-back call never drops and raises the strobe at once.
        @(negedge clk_in);
        for (int n = 0; n < 100 && cmd_ready_out !== 1'b1; n++) @(negedge clk_in);
        cmd_valid_in = 1'b1;
        cmd_mode_in  = m;
        baud_in      = b;
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
    endtask : set_mode

    task automatic test_reset();
        int n;
        chk_val("reset pins", 8'h1f, {3'h0, sck_out, sck_oe_out, sdo_out, sdo_oe_out, cs_n_out});
        chk_val("reset mode", 8'h01, {6'h0, mode_out});
        for (n = 0; n < 50 && cmd_ready_out !== 1'b1; n++) @(negedge clk_in);
        chk_val("startup cycles", 8'h04, n[7:0]);
        $display("test reset done");
    endtask : test_reset

    task automatic test_modes();
        logic [1:0] em[4] = '{2'b00, 2'b01, 2'b10, 2'b01};
        logic [7:0] eo[4] = '{8'h00, 8'h0f, 8'h1f, 8'h0f};
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1:0], 8'h02);
            chk_val("mode", {6'h0, em[m]}, {6'h0, mode_out});
            chk_val("pins", eo[m], {3'h0, req_ready_out, sck_oe_out, sck_out & sck_oe_out, sdo_oe_out,
                sdo_out & sdo_oe_out});
        end
        $display("test modes done");
    endtask : test_modes

    task automatic xfer(input logic [1:0] kind, input logic [7:0] tx, input logic [7:0] resp, input int b);
        int n;
        reply = resp;
        for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
        req_valid_in = 1'b1;
        req_kind_in  = kind;
        tx_data_in   = tx;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        for (n = 1; n < 300 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
        chk_val("frame cycles", 8'(16 * (b + 1) + 1), n[7:0]);
        chk_val("rx pulse", {7'h0, kind[1]}, {7'h0, rx_valid_out});
        chk_val("slave got", kind[0] ? tx : 8'hff, got);
        if (kind[1]) chk_val("rx data", resp, rx_data_out);
    endtask : xfer

    task automatic select(input logic v);
        cs_select_in = v;
        for (int n = 0; n < 50 && cs_n_out !== ~v; n++) @(negedge clk_in);
        chk_val("select", {7'h0, ~v}, {7'h0, cs_n_out});
    endtask : select

    task automatic test_stream();
        set_mode(smm_pkg::MODE_ENABLED, 8'h02);
        select(1'b1);
        xfer(smm_pkg::KIND_TRX, 8'ha5, 8'h3c, 2);
        xfer(smm_pkg::KIND_TX, 8'h81, 8'h00, 2);
        xfer(smm_pkg::KIND_RX, 8'h00, 8'hc3, 2);
        xfer(smm_pkg::KIND_TRX, 8'h7e, 8'h01, 2);
        select(1'b0);
        set_mode(smm_pkg::MODE_DISABLED, 8'h00);
        set_mode(smm_pkg::MODE_ENABLED, 8'h00);
        select(1'b1);
        xfer(smm_pkg::KIND_TX, 8'h5a, 8'h00, 0);
        select(1'b0);
        $display("test stream done");
    endtask : test_stream

    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    initial begin
        {clk_in, cmd_valid_in, req_valid_in, cs_select_in, sck_p, armed} = '0;
        {cmd_mode_in, req_kind_in, baud_in, tx_data_in, reply} = '0;
        {errors, comparisons, cycles, since_cs} = '0;
        since_rise = 1000;
        cs_p       = 1'b1;
        reset_in   = 1'b1;
        repeat (4) @(negedge clk_in);
        reset_in = 1'b0;
        test_reset();
        test_modes();
        test_stream();
        end_sim();
    end
endmodule : tb_spi_mode3_single_master
